// ===== src/escnt_pkg.sv
// Purpose: shared constants for the frame statistics counter bank
// Assumes: 32-bit Avalon-MM word bus, byte addresses
// Notes: counter bases and the irq registers are spaced 0x10 apart
package escnt_pkg;
	localparam int ESCNT_NUM = 5;
	localparam int ESCNT_W = 16;
	localparam int ESCNT_AW = 8;
	localparam int ESCNT_SHIFT = 4;
	localparam logic [ESCNT_W-1:0] ESCNT_CNT_RST = 16'h0000;
	// counter bases (byte addresses), each with base/clr/set/inv words
	localparam logic [ESCNT_AW-1:0] ESCNT_DROP_BASE = 8'h00;
	localparam logic [ESCNT_AW-1:0] ESCNT_TXOK_BASE = 8'h10;
	localparam logic [ESCNT_AW-1:0] ESCNT_SCOL_BASE = 8'h20;
	localparam logic [ESCNT_AW-1:0] ESCNT_MCOL_BASE = 8'h30;
	localparam logic [ESCNT_AW-1:0] ESCNT_RXOK_BASE = 8'h40;
	localparam logic [ESCNT_AW-1:0] ESCNT_IRQ_BASE = 8'h50;
	localparam logic [ESCNT_AW-1:0] ESCNT_MASK_BASE = 8'h60;
	localparam logic [1:0] ESCNT_ALIAS_BASE = 2'h0;
	localparam logic [1:0] ESCNT_ALIAS_CLR = 2'h1;
	localparam logic [1:0] ESCNT_ALIAS_SET = 2'h2;
	localparam logic [1:0] ESCNT_ALIAS_INV = 2'h3;
	localparam int ESCNT_IRQ_W = 1;
	localparam int ESCNT_RXOVF_BIT = 0;
	localparam logic [ESCNT_IRQ_W-1:0] ESCNT_IRQ_RST = 1'h0;
	localparam logic [31:0] ESCNT_UNMAPPED = 32'h00000000;
endpackage : escnt_pkg

// ===== src/escnt_counter.sv
// Purpose: one 16-bit statistics counter with alias writes and read clear
// Assumes: at most one bus operation per cycle
// Notes: a same-cycle event is applied after any software update
`timescale 1ns/1ps
module escnt_counter
	import escnt_pkg::*;
#(
	parameter int W = ESCNT_W
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic inc,
	input wire logic rd_clr,
	input wire logic wr_en,
	input wire logic [1:0] alias_sel,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] count
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} escnt_cst_t;

	escnt_cst_t st_r;
	escnt_cst_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (rd_clr)
			st_nxt.cnt = '0;
		else if (wr_en)
		begin
			case (alias_sel)
				ESCNT_ALIAS_BASE: st_nxt.cnt = wdata;
				ESCNT_ALIAS_CLR: st_nxt.cnt = st_r.cnt & ~wdata;
				ESCNT_ALIAS_SET: st_nxt.cnt = st_r.cnt | wdata;
				ESCNT_ALIAS_INV: st_nxt.cnt = st_r.cnt ^ wdata;
				default: st_nxt.cnt = st_r.cnt;
			endcase
		end
		// event kept on top of clear or write so no count is lost
		if (inc)
			st_nxt.cnt = st_nxt.cnt + 1'b1;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			st_r <= '{cnt: W'(ESCNT_CNT_RST)};
		else
			st_r <= st_nxt;
	end

	assign count = st_r.cnt;
endmodule : escnt_counter

// ===== src/escnt_top.sv
// Purpose: frame statistics counter bank with irq status and mask
// Assumes: event inputs are one-cycle pulses synchronous to CLOCK
// Notes: each access answers after one wait cycle
`timescale 1ns/1ps
module escnt_top
	import escnt_pkg::*;
#(
	parameter int W = ESCNT_W
)
(
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic [ESCNT_AW-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic RX_OVERRUN_DROP,
	input wire logic TX_DONE_OK,
	input wire logic TX_COLLISION_COUNT_ONE,
	input wire logic TX_COLLISION_COUNT_MANY,
	input wire logic RX_FILTER_ACCEPT,
	input wire logic RX_FCS_ERROR,
	input wire logic RX_ALIGN_ERROR,
	output logic IRQ
);
	////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0]
	{
		BUS_IDLE = 2'b01,
		BUS_ANSWER = 2'b10
	} escnt_bus_t;

	typedef struct packed {
		escnt_bus_t bus;
		logic wait_req;
		logic [31:0] rdata;
		logic [ESCNT_IRQ_W-1:0] irq_stat;
		logic [ESCNT_IRQ_W-1:0] irq_mask;
		logic irq;
	} escnt_st_t;

	// waitrequest idles high so a fresh request is never answered early
	localparam escnt_st_t ESCNT_ST_RST = '{
		bus: BUS_IDLE,
		wait_req: 1'b1,
		rdata: ESCNT_UNMAPPED,
		irq_stat: ESCNT_IRQ_RST,
		irq_mask: ESCNT_IRQ_RST,
		irq: 1'b0
	};

	escnt_st_t st_r;
	escnt_st_t st_nxt;

	logic [ESCNT_NUM-1:0] inc;
	logic [ESCNT_NUM-1:0] rd_clr;
	logic [ESCNT_NUM-1:0] wr_en;
	logic [W-1:0] count [ESCNT_NUM];
	logic [ESCNT_AW-1:0] base [ESCNT_NUM];
	logic [ESCNT_AW-1:0] word_base;
	logic [1:0] alias_sel;
	logic req;
	logic take;
	logic low_be;
	logic first;
	logic rd_first;
	logic wr_take;
	logic is_base;
	logic hit_irq;
	logic hit_mask;
	logic [ESCNT_NUM-1:0] hit_cnt;
	logic [W-1:0] rd_word [ESCNT_NUM];
	logic tx_one_col;
	logic tx_many_col;
	logic rx_bad;

	////////////////////////////////////////////////////////////////////
	assign req = AVS_READ | AVS_WRITE;
	// first edge of a request: read data and read clear are taken here,
	// so an event on this same edge lands after the clear and is kept
	assign first = req & (st_r.bus == BUS_IDLE);
	// answer edge: waitrequest is low and a write takes effect
	assign take = req & (st_r.bus == BUS_ANSWER);
	assign rd_first = first & AVS_READ;
	assign wr_take = take & AVS_WRITE;
	assign alias_sel = AVS_ADDRESS[ESCNT_SHIFT-1:ESCNT_SHIFT-$bits(alias_sel)];
	assign word_base = {AVS_ADDRESS[ESCNT_AW-1:ESCNT_SHIFT],
		{ESCNT_SHIFT{1'b0}}};
	assign low_be = AVS_BYTEENABLE[0] | AVS_BYTEENABLE[1];
	assign is_base = (alias_sel == ESCNT_ALIAS_BASE);
	assign hit_irq = (word_base == ESCNT_IRQ_BASE);
	assign hit_mask = (word_base == ESCNT_MASK_BASE);

	assign base[0] = ESCNT_DROP_BASE;
	assign base[1] = ESCNT_TXOK_BASE;
	assign base[2] = ESCNT_SCOL_BASE;
	assign base[3] = ESCNT_MCOL_BASE;
	assign base[4] = ESCNT_RXOK_BASE;

	// collision counts only qualify on a successful send
	assign tx_one_col = TX_DONE_OK & TX_COLLISION_COUNT_ONE;
	assign tx_many_col = TX_DONE_OK & TX_COLLISION_COUNT_MANY;
	// either receive error vetoes the accept pulse
	assign rx_bad = RX_FCS_ERROR | RX_ALIGN_ERROR;
	assign inc[0] = RX_OVERRUN_DROP;
	assign inc[1] = TX_DONE_OK;
	assign inc[2] = tx_one_col;
	assign inc[3] = tx_many_col;
	assign inc[4] = RX_FILTER_ACCEPT & ~rx_bad;

	////////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < ESCNT_NUM; gi++)
		begin : g_cnt
			logic hit;
			assign hit = (word_base == base[gi]);
			assign hit_cnt[gi] = hit;
			// zero unless this counter's base word is read
			assign rd_word[gi] = (hit & is_base) ? count[gi] : '0;
			// only the base word clears on read; alias reads return zero and clear nothing
			assign rd_clr[gi] = rd_first & hit & is_base & low_be;
			assign wr_en[gi] = wr_take & hit;
			escnt_counter #(
				.W(W)
			) u_cnt (
				.clk(CLOCK),
				.nrst(NRST),
				.inc(inc[gi]),
				.rd_clr(rd_clr[gi]),
				.wr_en(wr_en[gi]),
				.alias_sel(alias_sel),
				.wdata(AVS_WRITEDATA[W-1:0]),
				.count(count[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// one alias scheme for the status word, as for the counters
	function automatic logic [ESCNT_IRQ_W-1:0] escnt_alias(
		input logic [1:0] sel,
		input logic [ESCNT_IRQ_W-1:0] old,
		input logic [ESCNT_IRQ_W-1:0] wv
	);
		logic [ESCNT_IRQ_W-1:0] res;
		res = old;
		case (sel)
			ESCNT_ALIAS_BASE:
			begin
				res = wv;
			end
			ESCNT_ALIAS_CLR:
			begin
				res = old & ~wv;
			end
			ESCNT_ALIAS_SET:
			begin
				res = old | wv;
			end
			ESCNT_ALIAS_INV:
			begin
				res = old ^ wv;
			end
			default:
			begin
				res = old;
			end
		endcase
		return res;
	endfunction : escnt_alias

	////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic [ESCNT_IRQ_W-1:0] wv;
		logic [ESCNT_IRQ_W-1:0] ev;
		logic [W-1:0] rd_cnt;
		logic cnt_hit;
		wv = AVS_WRITEDATA[ESCNT_IRQ_W-1:0];
		ev = '0;
		rd_cnt = '0;
		cnt_hit = 1'b0;
		st_nxt = st_r;
		ev[ESCNT_RXOVF_BIT] = RX_OVERRUN_DROP;

		// bus handshake: one wait edge, then one answer edge
		case (st_r.bus)
			BUS_IDLE:
			begin
				if (req)
				begin
					st_nxt.bus = BUS_ANSWER;
					st_nxt.wait_req = 1'b0;
				end
				else
				begin
					st_nxt.bus = BUS_IDLE;
					st_nxt.wait_req = 1'b1;
				end
			end
			BUS_ANSWER:
			begin
				// the master drops or renews its request after this edge
				st_nxt.bus = BUS_IDLE;
				st_nxt.wait_req = 1'b1;
			end
			default:
			begin
				st_nxt.bus = BUS_IDLE;
				st_nxt.wait_req = 1'b1;
			end
		endcase

		// status and mask writes land on the answer edge
		if (wr_take & hit_irq)
		begin
			st_nxt.irq_stat = escnt_alias(alias_sel, st_r.irq_stat, wv);
		end
		else if (wr_take & hit_mask & is_base)
		begin
			st_nxt.irq_mask = wv;
		end
		// set beats a same-cycle clear
		st_nxt.irq_stat = st_nxt.irq_stat | ev;
		// taken from the next state so irq leaves a flop in step
		st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);

		// per-counter words are zero unless hit, so an or is the mux
		for (int i = 0; i < ESCNT_NUM; i++)
		begin
			rd_cnt = rd_cnt | rd_word[i];
			cnt_hit = cnt_hit | hit_cnt[i];
		end

		// captured on the first edge so it stands on the answer edge;
		// held until the next read, alias and unmapped words read zero
		if (rd_first)
		begin
			if (!is_base)
			begin
				st_nxt.rdata = ESCNT_UNMAPPED;
			end
			else if (cnt_hit)
			begin
				st_nxt.rdata = 32'(rd_cnt);
			end
			else if (hit_irq)
			begin
				st_nxt.rdata = 32'(st_r.irq_stat);
			end
			else if (hit_mask)
			begin
				st_nxt.rdata = 32'(st_r.irq_mask);
			end
			else
			begin
				st_nxt.rdata = ESCNT_UNMAPPED;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			st_r <= ESCNT_ST_RST;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// every output leaves straight from the state register
	assign AVS_WAITREQUEST = st_r.wait_req;
	assign AVS_READDATA = st_r.rdata;
	assign IRQ = st_r.irq;
endmodule : escnt_top

// ===== verification/escnt_monitor.sv
// Purpose: bus and irq checks on the escnt_top ports
// Assumes: one clock, NRST async active low
// Notes: counter values are judged by the bench
`timescale 1ns/1ps
module escnt_monitor
	import escnt_pkg::*;
(
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic [ESCNT_AW-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic RX_OVERRUN_DROP,
	input wire logic IRQ
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!NRST);
	////////////////////////////////////////////////////////////////////////
	ack_bound_a:
	assert property ((AVS_READ || AVS_WRITE) |-> ##[0:4] !AVS_WAITREQUEST)
		else $error("request not answered");
	ack_pulse_a:
	assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("wait low too long");
	idle_wait_a:
	assert property (!(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
		else $error("wait low while idle");
	no_early_a:
	assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
		else $error("answer on request edge");
	upper_zero_a:
	assert property (AVS_READ && !AVS_WAITREQUEST
		|-> AVS_READDATA[31:16] == 16'h0) else $error("upper bits set");
	alias_zero_a:
	assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[3:2] != 2'h0
		|-> AVS_READDATA == 32'h0) else $error("alias read nonzero");
	// irq is registered in step with status, so depth one would do; depth two is slack
	irq_rise_a:
	assert property ($rose(IRQ) |-> $past(RX_OVERRUN_DROP) || $past(AVS_WRITE)
		|| $past(RX_OVERRUN_DROP, 2) || $past(AVS_WRITE, 2))
		else $error("irq rose without cause");
	irq_fall_a:
	assert property ($fell(IRQ) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2))
		else $error("irq fell without write");
	cover property (AVS_READ && !AVS_WAITREQUEST);
	cover property ($rose(IRQ));
	cover property (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[3:2] == 2'h3);
endmodule : escnt_monitor
bind escnt_top escnt_monitor u_escnt_monitor (.CLOCK(CLOCK), .NRST(NRST),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.RX_OVERRUN_DROP(RX_OVERRUN_DROP), .IRQ(IRQ));

// ===== verification/tb_top.sv
// Purpose: register level bench for escnt_top
// Assumes: events are one-cycle pulses
// Notes: counts are read back through read clear
`timescale 1ns/1ps
module tb_top;
	import escnt_pkg::*;
	logic CLOCK = 0;
	logic NRST = 0;
	logic [7:0] adr = 0;
	logic rd_en = 0;
	logic wr_en = 0;
	logic [31:0] wd = 0;
	logic [3:0] be = 0;
	logic [31:0] rdata;
	logic [31:0] q;
	logic wt;
	logic irq;
	// bit order: drop, txok, one, many, accept, fcs, align
	logic [6:0] ev = 0;
	int n_errors = 0;
	int n_tests = 0;
	always #12.5 CLOCK = ~CLOCK;
	escnt_top u_escnt_top (.CLOCK(CLOCK), .NRST(NRST), .AVS_ADDRESS(adr),
		.AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wd),
		.AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wt),
		.RX_OVERRUN_DROP(ev[0]), .TX_DONE_OK(ev[1]),
		.TX_COLLISION_COUNT_ONE(ev[2]), .TX_COLLISION_COUNT_MANY(ev[3]),
		.RX_FILTER_ACCEPT(ev[4]), .RX_FCS_ERROR(ev[5]),
		.RX_ALIGN_ERROR(ev[6]), .IRQ(irq));
	////////////////////////////////////////////////////////////////////////
	task report_and_stop;
		if (n_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_errors++;
			$display("ERROR %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	// one spare edge after release keeps back-to-back strobes apart
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] b);
		adr <= a;
		wr_en <= w;
		rd_en <= !w;
		wd <= d;
		be <= b;
		do
			@(posedge CLOCK);
		while (wt !== 1'b0);
		q = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		@(posedge CLOCK);
	endtask : acc
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [3:0] b);
		acc(1'b0, a, 32'h0, b);
		chk(q, e);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d, 4'hf);
	endtask : wr
	task automatic pulse(input logic [6:0] v);
		ev <= v;
		@(posedge CLOCK);
		ev <= 7'h0;
		@(posedge CLOCK);
	endtask : pulse
	task automatic irq_is(input logic e);
		@(negedge CLOCK);
		chk({31'h0, irq}, {31'h0, e});
		@(posedge CLOCK);
	endtask : irq_is
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge CLOCK);
		NRST <= 1'b1;
		@(posedge CLOCK);
		for (int i = 0; i < 7; i++)
			rd(8'(i * 16), 32'h0, 4'hf);
		repeat (3) pulse(7'h02);
		pulse(7'h06);
		pulse(7'h0a);
		rd(8'h10, 32'h5, 4'hf);
		rd(8'h10, 32'h0, 4'hf);
		rd(8'h20, 32'h1, 4'hf);
		rd(8'h30, 32'h1, 4'hf);
		pulse(7'h10);
		pulse(7'h30);
		pulse(7'h50);
		rd(8'h40, 32'h1, 4'hf);
		pulse(7'h01);
		irq_is(1'b0);
		wr(8'h60, 32'h1);
		irq_is(1'b1);
		rd(8'h50, 32'h1, 4'hf);
		wr(8'h54, 32'h1);
		irq_is(1'b0);
		rd(8'h00, 32'h1, 4'hf);
		wr(8'h08, 32'h000f);
		wr(8'h04, 32'h0003);
		wr(8'h0c, 32'h0005);
		rd(8'h00, 32'h9, 4'hc);
		rd(8'h08, 32'h0, 4'hf);
		rd(8'h00, 32'h9, 4'hf);
		rd(8'h00, 32'h0, 4'hf);
		// event on the read-clear edge must survive the clear
		fork
			rd(8'h10, 32'h0, 4'hf);
			pulse(7'h02);
		join
		rd(8'h10, 32'h1, 4'hf);
		rd(8'h70, 32'h0, 4'hf);
		report_and_stop();
	end
	initial
	begin
		#50000;
		n_errors++;
		report_and_stop();
	end
endmodule : tb_top
